//--- fesw_pkg.sv
package fesw_pkg;
    // command opcodes
    localparam logic [7:0] OP_BLK32 = 8'h52;
    localparam logic [7:0] OP_BLK64 = 8'hd8;
    localparam logic [7:0] OP_ARR_A = 8'hc7;
    localparam logic [7:0] OP_ARR_B = 8'h60;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_VARM  = 8'h50;
    localparam logic [7:0] OP_RD1   = 8'h05;
    localparam logic [7:0] OP_RD2   = 8'h35;
    localparam logic [7:0] OP_RD3   = 8'h15;
    localparam logic [7:0] OP_WR1   = 8'h01;
    localparam logic [7:0] OP_WR2   = 8'h31;
    localparam logic [7:0] OP_WR3   = 8'h11;
    localparam logic [7:0] OP_QON   = 8'h38;
    localparam logic [7:0] OP_QOFF  = 8'hff;
    // frame lengths in received bits
    localparam logic [5:0] BITS_OP   = 6'h08;
    localparam logic [5:0] BITS_B1   = 6'h10;
    localparam logic [5:0] BITS_B2   = 6'h18;
    localparam logic [5:0] BITS_ADDR = 6'h20;
    localparam logic [5:0] BITS_SAT  = 6'h3b;
    // status field positions
    localparam int SR1_BUSY  = 0;
    localparam int SR1_LATCH = 1;
    localparam int SR1_BPLO = 2;
    localparam int SR1_BPHI = 6;
    localparam int SR2_PROT1 = 0;
    localparam int SR2_QUAD  = 1;
    localparam int SR2_COMPL = 6;
    localparam int SR3_PE   = 5;
    localparam int SR3_PROT = 6;
    // writable masks, otp lock mask, reset values
    localparam logic [7:0] SR1_WMASK = 8'hfc;
    localparam logic [7:0] SR2_WMASK = 8'h5f;
    localparam logic [7:0] SR3_WMASK = 8'h6f;
    localparam logic [7:0] LOCK_MASK = 8'h1c;
    localparam logic [7:0] SR1_RST   = 8'h00;
    localparam logic [7:0] SR2_RST   = 8'h00;
    localparam logic [7:0] SR3_RST   = 8'h00;
    // block alignment masks
    localparam logic [23:0] BLK32_MASK = 24'hff8000;
    localparam logic [23:0] BLK64_MASK = 24'hff0000;
    // self-timed cycle lengths in clk_in cycles
    localparam int unsigned BLK_ERASE_CYC = 32'h0001_0000;
    localparam int unsigned ARR_ERASE_CYC = 32'h0010_0000;
    localparam int unsigned STWR_CYC      = 32'h0000_2000;

    typedef enum logic [1:0] {ER_NONE, ER_32K, ER_64K, ER_ARRAY} fesw_erase_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_NVWR} fesw_state_t;
    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } fesw_link_t;
    typedef struct packed {
        fesw_erase_kind_t kind;
        logic [23:0]      addr;
    } fesw_erase_t;
    typedef struct packed {
        logic [7:0] sr3;
        logic [7:0] sr2;
        logic [7:0] sr1;
    } fesw_status_t;
endpackage

//--- fesw_timer.sv
// down-counter for self-timed erase and status write cycles
module fesw_timer #(
    parameter int unsigned CW = 32
) (
    input  wire logic          clk_in,
    input  wire logic          srst_in,
    input  wire logic          ce_in,
    input  wire logic          load_in,
    input  wire logic [CW-1:0] count_in,
    output logic               busy_out,
    output logic               done_out
);
    logic [CW-1:0] cnt_r;  // cycles left
    logic          done_r; // one-cycle end pulse

    // load wins over counting; a zero load never fires done
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else if (ce_in) begin
            done_r <= 1'b0;
            if (load_in) begin
                cnt_r <= count_in;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - CW'(1);
                if (cnt_r == CW'(1)) begin
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign busy_out = (cnt_r != '0);
    assign done_out = done_r;
endmodule

//--- fesw_ctrl.sv
// What this block does
// - 52h/D8h erase 32K/64K block, latch needed
// - block erase end clears write latch
// - erase starts on cs rise after address
// - C7h/60h erase whole array, latch needed
// - protected sectors refuse array erase, set errors
// - 06h sets write latch
// - latch cleared at power-up and write end
// - erase and nonvolatile status writes need latch
// - 04h clears write latch
// - 50h arms a status write in the next frame only
// - 05h/35h/15h read status, msb first
// - status read always allowed, repeats
// - 01h/31h/11h write only writable bits
// - lock bits one-time; volatile cannot clear protect1
// - nonvolatile needs latch, volatile needs arm
// - nonvolatile write busy cycle, then clears latch
// - volatile write updates soon, busy stays 0
// - reset reloads stored status into volatile
// - quad enable frozen in four-line mode
// - 01h with two bytes writes registers 1,2
// - 38h enters four-line command mode
// - FFh as two-clock cycle exits four-line mode
// - erase busy ignores all but status read
module fesw_ctrl #(
    parameter int unsigned BLK_ERASE_CYC = fesw_pkg::BLK_ERASE_CYC,
    parameter int unsigned ARR_ERASE_CYC = fesw_pkg::ARR_ERASE_CYC,
    parameter int unsigned STWR_CYC      = fesw_pkg::STWR_CYC
) (
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    input  wire logic                   ce_in,
    input  wire logic                   soft_rst_in,
    input  wire fesw_pkg::fesw_link_t   link_in,
    output logic [3:0]                  io_out,
    output logic [3:0]                  io_oe_out,
    output logic                        erase_start_out,
    output fesw_pkg::fesw_erase_t       erase_out,
    output fesw_pkg::fesw_status_t      status_out,
    output logic                        quad_mode_out
);
    fesw_pkg::fesw_link_t   link_s1_r;    // first sync stage
    fesw_pkg::fesw_link_t   link_s2_r;    // second sync stage
    fesw_pkg::fesw_link_t   link_s3_r;    // edge history
    logic [31:0]            shreg_r;      // received bits
    logic [31:0]            shreg_nxt;
    logic [5:0]             cnt_r;        // received bit count
    logic [5:0]             cnt_nxt;
    logic [7:0]             op_r;         // captured opcode
    logic                   latch_r;      // write_enable_latch
    logic                   arm_r;        // volatile write armed
    logic                   quad_r;       // four_line_command_mode
    fesw_pkg::fesw_state_t  st_r;         // self-timed activity
    fesw_pkg::fesw_status_t nv_r;         // stored status copy
    fesw_pkg::fesw_status_t vol_r;        // live status copy
    fesw_pkg::fesw_status_t pend_r;       // bytes awaiting commit
    logic [2:0]             pend_vld_r;   // which bytes are pending
    logic                   vpend_r;      // volatile commit next cycle
    fesw_pkg::fesw_status_t view;         // status as read out
    logic [7:0]             rd_byte_r;    // read shifter
    logic [2:0]             rd_idx_r;     // bit position in byte
    logic [3:0]             io_r;
    logic [3:0]             oe_r;
    logic                   erase_start_r;
    fesw_pkg::fesw_erase_t  erase_r;
    fesw_pkg::fesw_status_t status_r;
    logic                   tmr_load;
    logic [31:0]            tmr_cnt;
    logic                   tmr_done;
    logic                   cs_act;
    logic                   cs_rise;
    logic                   sck_rise;
    logic                   sck_fall;
    logic                   frame_end;
    logic                   go;
    logic                   n_op;
    logic                   busy;
    logic                   prot_any;
    logic                   is_blk;
    logic                   is_arr;
    logic                   arr_ok;
    logic                   arr_ref;
    logic                   is_stwr;
    logic                   nv_wr;
    logic                   v_wr;
    logic                   rd_act;

    // status read opcode to register index, 2'h3 when not a read
    function automatic logic [1:0] rd_sel(input logic [7:0] op);
        case (op)
            fesw_pkg::OP_RD1: rd_sel = 2'h0;
            fesw_pkg::OP_RD2: rd_sel = 2'h1;
            fesw_pkg::OP_RD3: rd_sel = 2'h2;
            default:          rd_sel = 2'h3;
        endcase
    endfunction

    // status write opcode to register index, 2'h3 when not a write
    function automatic logic [1:0] wr_sel(input logic [7:0] op);
        case (op)
            fesw_pkg::OP_WR1: wr_sel = 2'h0;
            fesw_pkg::OP_WR2: wr_sel = 2'h1;
            fesw_pkg::OP_WR3: wr_sel = 2'h2;
            default:          wr_sel = 2'h3;
        endcase
    endfunction

    // merge written bytes, keeping read-only and locked bits
    function automatic fesw_pkg::fesw_status_t merge(input fesw_pkg::fesw_status_t b,
        input fesw_pkg::fesw_status_t d, input logic [2:0] v, input logic vw, input logic q);
        fesw_pkg::fesw_status_t r;
        r = b;
        if (v[0]) begin
            r.sr1 = (b.sr1 & ~fesw_pkg::SR1_WMASK) | (d.sr1 & fesw_pkg::SR1_WMASK);
        end
        if (v[1]) begin
            r.sr2 = (b.sr2 & ~fesw_pkg::SR2_WMASK) | (d.sr2 & fesw_pkg::SR2_WMASK);
            r.sr2 = r.sr2 | (b.sr2 & fesw_pkg::LOCK_MASK);
            if (vw) begin
                r.sr2[fesw_pkg::SR2_PROT1] = r.sr2[fesw_pkg::SR2_PROT1] | b.sr2[fesw_pkg::SR2_PROT1];
            end
            if (q) begin
                r.sr2[fesw_pkg::SR2_QUAD] = b.sr2[fesw_pkg::SR2_QUAD];
            end
        end
        if (v[2]) begin
            r.sr3 = (b.sr3 & ~fesw_pkg::SR3_WMASK) | (d.sr3 & fesw_pkg::SR3_WMASK);
        end
        return r;
    endfunction

    // two-stage sync of all link pins, third stage only for edges
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            link_s1_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            link_s2_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            link_s3_r <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
        end else if (ce_in) begin
            link_s1_r <= link_in;
            link_s2_r <= link_s1_r;
            link_s3_r <= link_s2_r;
        end
    end

    assign cs_act    = !link_s2_r.cs_n;
    assign cs_rise   = link_s2_r.cs_n & !link_s3_r.cs_n;
    assign sck_rise  = cs_act & link_s2_r.sck & !link_s3_r.sck;
    assign sck_fall  = cs_act & !link_s2_r.sck & link_s3_r.sck;
    assign frame_end = ce_in & cs_rise;
    assign busy      = (st_r != fesw_pkg::ST_IDLE);
    // a busy device takes no command; reads run in their own path
    assign go        = frame_end & !busy;
    assign n_op      = (cnt_r == fesw_pkg::BITS_OP);

    // next shift value: one line in serial, four in quad mode
    always_comb begin
        if (quad_r) begin
            shreg_nxt = {shreg_r[27:0], link_s2_r.io};
        end else begin
            shreg_nxt = {shreg_r[30:0], link_s2_r.io[0]};
        end
        if (cnt_r > fesw_pkg::BITS_SAT) begin
            cnt_nxt = 6'h3f;
        end else begin
            cnt_nxt = cnt_r + (quad_r ? 6'h04 : 6'h01);
        end
    end

    // sample on rising sck; overlong frames saturate and drop
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            shreg_r <= 32'h0000_0000;
            cnt_r   <= 6'h00;
            op_r    <= 8'h00;
        end else if (ce_in) begin
            if (!cs_act) begin
                cnt_r <= 6'h00;
            end else if (sck_rise) begin
                shreg_r <= shreg_nxt;
                cnt_r   <= cnt_nxt;
                if (cnt_nxt == fesw_pkg::BITS_OP) begin
                    op_r <= shreg_nxt[7:0];
                end
            end
        end
    end

    // command classes, all judged when chip select rises
    assign prot_any = vol_r.sr2[fesw_pkg::SR2_COMPL]
                    | (vol_r.sr1[fesw_pkg::SR1_BPHI:fesw_pkg::SR1_BPLO] != 5'h00);
    assign is_blk   = go & latch_r & (cnt_r == fesw_pkg::BITS_ADDR)
                    & (op_r == fesw_pkg::OP_BLK32 || op_r == fesw_pkg::OP_BLK64);
    assign is_arr   = go & latch_r & n_op & (op_r == fesw_pkg::OP_ARR_A || op_r == fesw_pkg::OP_ARR_B);
    assign arr_ok   = is_arr & !prot_any;
    assign arr_ref  = is_arr & prot_any;
    assign is_stwr  = go & (wr_sel(op_r) != 2'h3) & ((cnt_r == fesw_pkg::BITS_B1)
                    | ((op_r == fesw_pkg::OP_WR1) & (cnt_r == fesw_pkg::BITS_B2)));
    assign nv_wr    = is_stwr & latch_r;
    assign v_wr     = is_stwr & !latch_r & arm_r;
    assign tmr_load = ce_in & (is_blk | arr_ok | nv_wr);
    assign tmr_cnt  = is_blk ? 32'(BLK_ERASE_CYC) : (arr_ok ? 32'(ARR_ERASE_CYC) : 32'(STWR_CYC));

    // self-timed cycle length
    fesw_timer #(
        .CW (32)
    ) u_timer (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .ce_in    (ce_in),
        .load_in  (tmr_load),
        .count_in (tmr_cnt),
        .busy_out (),
        .done_out (tmr_done)
    );

    // activity state: idle, erasing or storing status
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r <= fesw_pkg::ST_IDLE;
        end else if (ce_in) begin
            case (st_r)
                fesw_pkg::ST_IDLE: begin
                    if (is_blk || arr_ok) begin
                        st_r <= fesw_pkg::ST_ERASE;
                    end else if (nv_wr) begin
                        st_r <= fesw_pkg::ST_NVWR;
                    end
                end
                fesw_pkg::ST_ERASE, fesw_pkg::ST_NVWR: begin
                    if (tmr_done) begin
                        st_r <= fesw_pkg::ST_IDLE;
                    end
                end
                default: st_r <= fesw_pkg::ST_IDLE;
            endcase
        end
    end

    // write enable latch; completion of any self-timed write clears it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            latch_r <= 1'b0;
        end else if (ce_in) begin
            if (soft_rst_in || tmr_done) begin
                latch_r <= 1'b0;
            end else if (go && n_op && op_r == fesw_pkg::OP_LATCH_SET) begin
                latch_r <= 1'b1;
            end else if (go && n_op && op_r == fesw_pkg::OP_LATCH_CLR) begin
                latch_r <= 1'b0;
            end
        end
    end

    // volatile arm lives for exactly one following frame
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            arm_r <= 1'b0;
        end else if (ce_in) begin
            if (soft_rst_in) begin
                arm_r <= 1'b0;
            end else if (go && n_op && op_r == fesw_pkg::OP_VARM) begin
                arm_r <= 1'b1;
            end else if (frame_end) begin
                arm_r <= 1'b0;
            end
        end
    end

    // four-line mode; entry requires quad enable already set
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            quad_r <= 1'b0;
        end else if (ce_in && go && n_op) begin
            if (!quad_r && op_r == fesw_pkg::OP_QON && vol_r.sr2[fesw_pkg::SR2_QUAD]) begin
                quad_r <= 1'b1;
            end else if (quad_r && op_r == fesw_pkg::OP_QOFF) begin
                quad_r <= 1'b0;
            end
        end
    end

    // capture written bytes; the two-byte form fills registers 1 and 2
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pend_r     <= '0;
            pend_vld_r <= 3'h0;
            vpend_r    <= 1'b0;
        end else if (ce_in) begin
            vpend_r <= v_wr;
            if (nv_wr || v_wr) begin
                pend_r <= '{sr3: shreg_r[7:0], sr2: shreg_r[7:0], sr1: shreg_r[7:0]};
                if (cnt_r == fesw_pkg::BITS_B2) begin
                    pend_r.sr1 <= shreg_r[15:8];
                    pend_vld_r <= 3'h3;
                end else begin
                    pend_vld_r <= 3'(1 << wr_sel(op_r));
                end
            end
        end
    end

    // status copies; error flags set last so they win
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nv_r  <= '{sr3: fesw_pkg::SR3_RST, sr2: fesw_pkg::SR2_RST, sr1: fesw_pkg::SR1_RST};
            vol_r <= '{sr3: fesw_pkg::SR3_RST, sr2: fesw_pkg::SR2_RST, sr1: fesw_pkg::SR1_RST};
        end else if (ce_in) begin
            if (soft_rst_in) begin
                vol_r <= nv_r;
            end else begin
                if (vpend_r) begin
                    vol_r <= merge(vol_r, pend_r, pend_vld_r, 1'b1, quad_r);
                end
                if (st_r == fesw_pkg::ST_NVWR && tmr_done) begin
                    nv_r  <= merge(nv_r, pend_r, pend_vld_r, 1'b0, quad_r);
                    vol_r <= merge(nv_r, pend_r, pend_vld_r, 1'b0, quad_r);
                end
                if (arr_ref) begin
                    vol_r.sr3[fesw_pkg::SR3_PE]   <= 1'b1;
                    vol_r.sr3[fesw_pkg::SR3_PROT] <= 1'b1;
                end
            end
        end
    end

    // erase request out; the address is aligned to its block
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            erase_start_r <= 1'b0;
            erase_r       <= '{kind: fesw_pkg::ER_NONE, addr: 24'h000000};
        end else if (ce_in) begin
            erase_start_r <= is_blk | arr_ok;
            if (is_blk && op_r == fesw_pkg::OP_BLK32) begin
                erase_r <= '{kind: fesw_pkg::ER_32K, addr: shreg_r[23:0] & fesw_pkg::BLK32_MASK};
            end else if (is_blk) begin
                erase_r <= '{kind: fesw_pkg::ER_64K, addr: shreg_r[23:0] & fesw_pkg::BLK64_MASK};
            end else if (arr_ok) begin
                erase_r <= '{kind: fesw_pkg::ER_ARRAY, addr: 24'h000000};
            end
        end
    end

    // visible status: busy and latch live in register 1
    always_comb begin
        view = vol_r;
        view.sr1[fesw_pkg::SR1_BUSY]  = busy;
        view.sr1[fesw_pkg::SR1_LATCH] = latch_r;
    end

    // reads run even while busy; byte reloaded each time so busy is live
    assign rd_act = cs_act & (rd_sel(op_r) != 2'h3) & (cnt_r >= fesw_pkg::BITS_OP);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_byte_r <= 8'h00;
            rd_idx_r  <= 3'h0;
            io_r      <= 4'h0;
            oe_r      <= 4'h0;
        end else if (ce_in) begin
            if (!cs_act) begin
                rd_idx_r <= 3'h0;
                oe_r     <= 4'h0;
            end else if (sck_fall && rd_act) begin
                logic [7:0] byt;
                byt = (rd_idx_r == 3'h0) ? view[rd_sel(op_r)*8 +: 8] : rd_byte_r;
                if (quad_r) begin
                    io_r      <= byt[7:4];
                    oe_r      <= 4'hf;
                    rd_byte_r <= {byt[3:0], 4'h0};
                    rd_idx_r  <= rd_idx_r + 3'h4;
                end else begin
                    io_r      <= {2'h0, byt[7], 1'b0};
                    oe_r      <= 4'h2;
                    rd_byte_r <= {byt[6:0], 1'b0};
                    rd_idx_r  <= rd_idx_r + 3'h1;
                end
            end
        end
    end

    // registered status view
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_r <= '0;
        end else if (ce_in) begin
            status_r <= view;
        end
    end

    assign io_out          = io_r;
    assign io_oe_out       = oe_r;
    assign erase_start_out = erase_start_r;
    assign erase_out       = erase_r;
    assign status_out      = status_r;
    assign quad_mode_out   = quad_r;

    latch_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
        go && n_op && op_r == fesw_pkg::OP_LATCH_SET && !soft_rst_in |=> latch_r)
        else $error("write enable did not set latch");
    latch_clr_a: assert property (@(posedge clk_in) disable iff (srst_in)
        go && n_op && op_r == fesw_pkg::OP_LATCH_CLR |=> !latch_r)
        else $error("write disable did not clear latch");
    erase_gate_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(erase_start_out) |-> $past(latch_r) && $past(go))
        else $error("erase started without latch or frame end");
    erase_end_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && st_r == fesw_pkg::ST_ERASE && tmr_done |=> !latch_r && !busy)
        else $error("erase end left latch or busy set");
    arr_refuse_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && arr_ref && !soft_rst_in |=> vol_r.sr3[fesw_pkg::SR3_PE] && vol_r.sr3[fesw_pkg::SR3_PROT]
        && !erase_start_out && !busy)
        else $error("protected array erase not refused");
    busy_ign_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && busy && !tmr_done && !soft_rst_in |=> $stable(latch_r) && $stable(quad_r))
        else $error("command taken while busy");
    vol_busy_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && v_wr |=> vpend_r && !busy ##1 !busy)
        else $error("volatile write raised busy");
    align_a: assert property (@(posedge clk_in) disable iff (srst_in)
        erase_start_out && erase_out.kind == fesw_pkg::ER_64K |-> erase_out.addr[15:0] == 16'h0000)
        else $error("64K erase address not aligned");
    quad_exit_a: assert property (@(posedge clk_in) disable iff (srst_in)
        quad_r && go && n_op && op_r == fesw_pkg::OP_QOFF |=> !quad_mode_out)
        else $error("four-line exit ignored");
endmodule

//--- fesw_host.sv
// host controller model: spi mode 0, sck idle low and halted between frames
module fesw_host (
    input  wire logic            clk_in,
    input  wire logic [3:0]      io_in,
    output fesw_pkg::fesw_link_t link_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] rx_r;  // samples of the device output line
    initial link_out = 6'h20;
    // shift n units of d msb first; quad sends one nibble per clock
    task automatic frame(input logic [63:0] d, input int n, input bit quad);
        @(posedge clk_in) #1 link_out.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            link_out.io = quad ? d[63:60] : {4{d[63]}};
            d = quad ? d << 4 : d << 1;
            repeat (8) @(posedge clk_in);
            #1 rx_r = {rx_r[62:0], io_in[1]};
            link_out.sck = 1'b1;
            repeat (8) @(posedge clk_in);
            #1 link_out.sck = 1'b0;
        end
        repeat (8) @(posedge clk_in);
        #1 link_out.cs_n = 1'b1;
        link_out.io = ~link_out.io; // no pull on the lines, so show the inverse
        repeat (8) @(posedge clk_in);
    endtask
endmodule

//--- tb.sv
// self-checking bench: latch, erases, status writes, four-line mode
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   clk_in = 1'b0, srst_in = 1'b1, soft_rst_in = 1'b0;
    fesw_pkg::fesw_link_t   lk;                // host pins
    logic [3:0]             io_out, io_oe_out, pin_io;
    logic                   erase_start_out, quad_mode_out;
    fesw_pkg::fesw_erase_t  erase_out;
    fesw_pkg::fesw_status_t status_out;
    int                     err_total = 0, cmp_count = 0, starts = 0;
    logic [23:0]            a;                 // random address or data
    logic [7:0]             ops [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
    logic [23:0]            msk [4] = '{24'hff8000, 24'hff0000, 24'h0, 24'h0};
    assign pin_io = (io_oe_out & io_out) | (~io_oe_out & lk.io); // wire level
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (erase_start_out === 1'b1) starts++; // erases taken
    fesw_ctrl #(.BLK_ERASE_CYC(1000), .ARR_ERASE_CYC(1000), .STWR_CYC(1000)) u_dut (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .soft_rst_in(soft_rst_in),
        .link_in({lk.cs_n, lk.sck, pin_io}), .io_out(io_out), .io_oe_out(io_oe_out),
        .erase_start_out(erase_start_out), .erase_out(erase_out), .status_out(status_out),
        .quad_mode_out(quad_mode_out));
    fesw_host u_host (.clk_in(clk_in), .io_in(pin_io), .link_out(lk));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // expected erase base: block aligned down, whole array at zero
    function automatic logic [23:0] exp_addr(input int k, input logic [23:0] ad);
        return ad & msk[k];
    endfunction
    task automatic f(input logic [63:0] d, input int n, input bit q = 1'b0);
        u_host.frame(d, n, q);
    endtask
    task automatic op(input logic [7:0] o);
        f({o, 56'h0}, 8);
    endtask
    // bounded wait for busy to drop, plus settling
    task automatic idle();
        for (int i = 0; i < 3000 && status_out.sr1[0] !== 1'b0; i++) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task automatic test_done();
        $display("%0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #500_000 err_total++;
        test_done();
    end
    initial begin
        void'($urandom(32'h3f099fb7));
        repeat (12) @(posedge clk_in);
        #1 srst_in = 1'b0;
        idle();
        check(status_out, 24'h0);
        f({8'hd8, 24'h123456, 32'h0}, 32);
        check(starts, 0);
        op(8'h06);
        check(status_out.sr1, 8'h02);
        f({8'hd8, 24'h123456, 32'h0}, 24);
        check(starts, 0);
        op(8'h04);
        check(status_out.sr1, 8'h00);
        $display("latch test ended");
        for (int k = 0; k < 4; k++) begin
            a = 24'($urandom);
            op(8'h06);
            f({ops[k], a, 32'h0}, k < 2 ? 32 : 8);
            check(starts, k + 1);
            check(erase_out.kind, k < 2 ? k + 1 : 3);
            check(erase_out.addr, exp_addr(k, a));
            f({8'h05, 56'h0}, 24);
            check(u_host.rx_r[15:0], 16'h0303);
            op(8'h04);
            check(status_out.sr1, 8'h03);
            idle();
            check(status_out.sr1, 8'h00);
        end
        $display("erase test ended");
        a = 24'($urandom) | 24'h4;
        op(8'h50);
        f({8'h01, a[7:0], 48'h0}, 16);
        idle();
        check(status_out.sr1, a[7:0] & 8'hfc);
        op(8'h06);
        op(8'hc7);
        check(starts, 4);
        check(status_out.sr3, 8'h60);
        f({8'h15, 56'h0}, 16);
        check(u_host.rx_r[7:0], 8'h60);
        op(8'h50);
        op(8'h04);
        f({8'h01, 56'h0}, 16);
        idle();
        check(status_out.sr1, a[7:0] & 8'hfc);
        op(8'h50);
        f({8'h11, 8'hff, 48'h0}, 16);
        idle();
        check(status_out.sr3, 8'h6f);
        @(posedge clk_in) #1 soft_rst_in = 1'b1;
        @(posedge clk_in) #1 soft_rst_in = 1'b0;
        idle();
        check(status_out, 24'h0);
        op(8'h06);
        f({8'h01, 16'h8040, 40'h0}, 24);
        check(status_out.sr1[1:0], 2'h3);
        idle();
        check(status_out[15:0], 16'h4080);
        f({8'h35, 56'h0}, 16);
        check(u_host.rx_r[7:0], 8'h40);
        op(8'h50);
        f({8'h31, 8'h02, 48'h0}, 16);
        op(8'h38);
        check(quad_mode_out, 1'b1);
        f({8'h50, 56'h0}, 2, 1'b1);
        f({8'h31, 56'h0}, 4, 1'b1);
        idle();
        check(status_out.sr2, 8'h02);
        f({8'hff, 56'h0}, 2, 1'b1);
        check(quad_mode_out, 1'b0);
        op(8'h50);
        f({8'h31, 8'h1d, 48'h0}, 16);
        op(8'h50);
        f({8'h31, 8'h00, 48'h0}, 16);
        idle();
        check(status_out.sr2, 8'h1d);
        $display("status test ended");
        test_done();
    end
endmodule
